/* inc/pdc_map.svh */
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH

// Register indices; byte address is four times the index
`define PDC_IDX_FRONT_CFG 6'h0d
`define PDC_IDX_GEN_CFG 6'h0e
`define PDC_IDX_LOCK_DATA 6'h10
`define PDC_IDX_GEN_DATA 6'h11
`define PDC_IDX_FRONT_STAT 6'h12
`define PDC_IDX_IRQ_ROUTE 6'h13

// Reset values
`define PDC_RST_FRONT_CFG 8'hff
`define PDC_RST_GEN_DIR 5'h00
`define PDC_RST_GEN_DATA 5'h00
`define PDC_RST_ROUTE_LEVEL 4'h0

// Field positions of the general pin configuration register
`define PDC_GEN_SPARE_EN_BIT 7
`define PDC_GEN_LOCK_DIR_BIT 6
`define PDC_GEN_RSVD_BIT 5
`define PDC_GEN_DIR_MSB 4

// Field positions of the data and routing registers
`define PDC_LOCK_DATA_BIT 0
`define PDC_GDATA_SPARE_BIT 7
`define PDC_GDATA_MSB 4
`define PDC_ROUTE_LEVEL_MSB 3
`define PDC_ROUTE_HIGH_BIT 4

// Interrupt level whose line shares the spare pin in plug-and-play mode
`define PDC_SPARE_IRQ_LEVEL 4'hb

// Pin counts and synchroniser width
`define PDC_FRONT_PINS 8
`define PDC_GEN_PINS 5
`define PDC_SYNC_W 16

`endif

/* inc/pdc_pkg.sv */
package pdc_pkg;

  typedef enum logic [2:0]
  {
    PDC_REG_NONE,
    PDC_REG_FRONT_CFG,
    PDC_REG_GEN_CFG,
    PDC_REG_LOCK_DATA,
    PDC_REG_GEN_DATA,
    PDC_REG_FRONT_STAT,
    PDC_REG_IRQ_ROUTE
  } pdc_reg_e;

  typedef logic [7:0] pdc_byte_t;

endpackage

/* hw/pdc_sync.sv */
`timescale 1ns/1ps

module pdc_sync
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // First stage is read only by the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

/* hw/pdc_top.sv */
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "pdc_map.svh"

// Overview of operation
// - Front config bit 7 enables link LED pin drive, reset value one.
// - Front config bit 6 enables low front-end power pin, reset one.
// - Front config bit 5 enables high front-end power pin, reset one.
// - Front config bit 4 enables synthesizer clock pin, reset one.
// - Front config bits 3..1 enable synthesizer select lines 3..1, reset one.
// - Front config bit 0 enables receive power pin; register resets to ff.
// - General config bit 7, reset zero, with routing and strap selects spare pin.
// - Lock pin driven high and low when direction bit and strap are both one.
// - Driven lock pin level follows the lock data bit.
// - Lock direction bit zero puts lock pin in high impedance.
// - Lock data read returns the actual lock pin level, strap regardless.
// - General config bit 5 is written zero by software; reads return zero.
// - General config bits 4:0 reset zero; a one enables that general pin drive.
// - A driven general pin takes its level from its general data bit.
// - A general pin with direction zero is put in high impedance.
// - General data read returns actual pin levels, not written values.
module pdc_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Bus mode strap pin, one selects card mode
  input wire logic bus_mode_strap_i,
  // Internal function sources for the front-end pins
  input wire logic [7:0] front_fn_i,
  // Front-end pins: 7 link LED, 6 low power, 5 high power, 4 synth clock,
  // 3..1 synth select lines, 0 receive power
  input wire logic [7:0] front_pins_i,
  output logic [7:0] front_pins_o,
  output logic [7:0] front_pins_oe_o,
  // Lock enable pin
  input wire logic lock_enable_pin_i,
  output logic lock_enable_pin_o,
  output logic lock_enable_pin_oe_o,
  // General pins
  input wire logic [4:0] general_pin_i,
  output logic [4:0] general_pin_o,
  output logic [4:0] general_pin_oe_o,
  // Spare pin seven and the interrupt request that may share it
  input wire logic spare_pin_seven_i,
  input wire logic spare_irq_req_i,
  output logic spare_pin_seven_o,
  output logic spare_pin_seven_oe_o
);

  // Configuration and data state
  logic [7:0] pin_config_front_end_reg;
  logic [4:0] general_pin_direction_reg;
  logic lock_pin_direction_reg;
  logic spare_pin_seven_enable_reg;
  logic lock_data_reg;
  logic [4:0] general_pin_data_reg;
  logic spare_data_reg;
  logic [3:0] route_level_reg;
  logic route_high_reg;

  // Bus handshake
  logic ack_reg;
  logic bus_req;
  logic bus_wr;
  pdc_pkg::pdc_reg_e reg_sel;
  pdc_pkg::pdc_byte_t rd_next;

  // Synchronised pin levels
  logic [`PDC_SYNC_W-1:0] pins_async;
  logic [`PDC_SYNC_W-1:0] pins_sync;
  logic strap_s;
  logic spare_s;
  logic lock_s;
  logic [4:0] general_s;
  logic [7:0] front_s;

  // Spare pin routing
  logic spare_is_irq;
  logic spare_irq_level;

  assign pins_async = {bus_mode_strap_i, spare_pin_seven_i, lock_enable_pin_i, general_pin_i, front_pins_i};

  // Every pin level, strap included, crosses two flops before use
  pdc_sync
  #(
    .WIDTH(`PDC_SYNC_W)
  )
  u_sync
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pins_async),
    .sync_o(pins_sync)
  );

  assign front_s = pins_sync[7:0];
  assign general_s = pins_sync[12:8];
  assign lock_s = pins_sync[13];
  assign spare_s = pins_sync[14];
  // Strap is a static level; the synchronised copy is used throughout
  assign strap_s = pins_sync[15];

  // Wishbone decode; one request is answered one cycle after it is seen
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];

  always_comb
  begin
    reg_sel = pdc_pkg::PDC_REG_NONE;
    unique case (wb_adr_i[7:2])
      `PDC_IDX_FRONT_CFG:
      begin
        reg_sel = pdc_pkg::PDC_REG_FRONT_CFG;
      end
      `PDC_IDX_GEN_CFG:
      begin
        reg_sel = pdc_pkg::PDC_REG_GEN_CFG;
      end
      `PDC_IDX_LOCK_DATA:
      begin
        reg_sel = pdc_pkg::PDC_REG_LOCK_DATA;
      end
      `PDC_IDX_GEN_DATA:
      begin
        reg_sel = pdc_pkg::PDC_REG_GEN_DATA;
      end
      `PDC_IDX_FRONT_STAT:
      begin
        reg_sel = pdc_pkg::PDC_REG_FRONT_STAT;
      end
      `PDC_IDX_IRQ_ROUTE:
      begin
        reg_sel = pdc_pkg::PDC_REG_IRQ_ROUTE;
      end
      default:
      begin
        reg_sel = pdc_pkg::PDC_REG_NONE;
      end
    endcase
  end

  // Read data; data registers return pin levels, not stored values
  always_comb
  begin
    rd_next = 8'h00;
    unique case (reg_sel)
      pdc_pkg::PDC_REG_FRONT_CFG:
      begin
        rd_next = pin_config_front_end_reg;
      end
      pdc_pkg::PDC_REG_GEN_CFG:
      begin
        // Reserved bit 5 reads zero
        rd_next = {spare_pin_seven_enable_reg, lock_pin_direction_reg, 1'b0, general_pin_direction_reg};
      end
      pdc_pkg::PDC_REG_LOCK_DATA:
      begin
        rd_next[`PDC_LOCK_DATA_BIT] = lock_s;
      end
      pdc_pkg::PDC_REG_GEN_DATA:
      begin
        rd_next[`PDC_GDATA_MSB:0] = general_s;
        rd_next[`PDC_GDATA_SPARE_BIT] = spare_s;
      end
      pdc_pkg::PDC_REG_FRONT_STAT:
      begin
        rd_next = front_s;
      end
      pdc_pkg::PDC_REG_IRQ_ROUTE:
      begin
        rd_next[`PDC_ROUTE_LEVEL_MSB:0] = route_level_reg;
        rd_next[`PDC_ROUTE_HIGH_BIT] = route_high_reg;
      end
      pdc_pkg::PDC_REG_NONE:
      begin
        rd_next = 8'h00;
      end
    endcase
  end

  // Acknowledge and read data; unmapped addresses ack with zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= bus_req;
      wb_ack_o <= bus_req;
      if (bus_req)
      begin
        wb_dat_o <= {24'h00_0000, rd_next};
      end
    end
  end

  // Front-end configuration, all enables set out of reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_config_front_end_reg <= `PDC_RST_FRONT_CFG;
    end
    else if (bus_wr && reg_sel == pdc_pkg::PDC_REG_FRONT_CFG)
    begin
      pin_config_front_end_reg <= wb_dat_i[7:0];
    end
  end

  // General configuration; bit 5 is not stored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      spare_pin_seven_enable_reg <= 1'b0;
      lock_pin_direction_reg <= 1'b0;
      general_pin_direction_reg <= `PDC_RST_GEN_DIR;
    end
    else if (bus_wr && reg_sel == pdc_pkg::PDC_REG_GEN_CFG)
    begin
      spare_pin_seven_enable_reg <= wb_dat_i[`PDC_GEN_SPARE_EN_BIT];
      lock_pin_direction_reg <= wb_dat_i[`PDC_GEN_LOCK_DIR_BIT];
      general_pin_direction_reg <= wb_dat_i[`PDC_GEN_DIR_MSB:0];
    end
  end

  // Lock data bit; the written value drives the pin, reads see the pin
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lock_data_reg <= 1'b0;
    end
    else if (bus_wr && reg_sel == pdc_pkg::PDC_REG_LOCK_DATA)
    begin
      lock_data_reg <= wb_dat_i[`PDC_LOCK_DATA_BIT];
    end
  end

  // General data bits, including the spare pin seven data bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      general_pin_data_reg <= `PDC_RST_GEN_DATA;
      spare_data_reg <= 1'b0;
    end
    else if (bus_wr && reg_sel == pdc_pkg::PDC_REG_GEN_DATA)
    begin
      general_pin_data_reg <= wb_dat_i[`PDC_GDATA_MSB:0];
      spare_data_reg <= wb_dat_i[`PDC_GDATA_SPARE_BIT];
    end
  end

  // Plug-and-play interrupt level and type
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      route_level_reg <= `PDC_RST_ROUTE_LEVEL;
      route_high_reg <= 1'b0;
    end
    else if (bus_wr && reg_sel == pdc_pkg::PDC_REG_IRQ_ROUTE)
    begin
      route_level_reg <= wb_dat_i[`PDC_ROUTE_LEVEL_MSB:0];
      route_high_reg <= wb_dat_i[`PDC_ROUTE_HIGH_BIT];
    end
  end

  // Front-end pins: enable set drives the function, clear floats the pin
  genvar fi;
  generate
    for (fi = 0; fi < `PDC_FRONT_PINS; fi = fi + 1)
    begin : g_front
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          front_pins_o[fi] <= 1'b0;
          front_pins_oe_o[fi] <= 1'b0;
        end
        else
        begin
          front_pins_o[fi] <= front_fn_i[fi];
          front_pins_oe_o[fi] <= pin_config_front_end_reg[fi];
        end
      end
    end
  endgenerate

  // General pins: direction bit gates the drive of the data bit
  genvar gi;
  generate
    for (gi = 0; gi < `PDC_GEN_PINS; gi = gi + 1)
    begin : g_general
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          general_pin_o[gi] <= 1'b0;
          general_pin_oe_o[gi] <= 1'b0;
        end
        else
        begin
          general_pin_o[gi] <= general_pin_data_reg[gi];
          general_pin_oe_o[gi] <= general_pin_direction_reg[gi];
        end
      end
    end
  endgenerate

  // Lock pin is an address input in plug-and-play mode, so the strap gates it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lock_enable_pin_o <= 1'b0;
      lock_enable_pin_oe_o <= 1'b0;
    end
    else
    begin
      lock_enable_pin_o <= lock_data_reg;
      lock_enable_pin_oe_o <= lock_pin_direction_reg & strap_s;
    end
  end

  // Interrupt routing to the spare pin only exists in plug-and-play mode
  assign spare_is_irq = ~strap_s & (route_level_reg == `PDC_SPARE_IRQ_LEVEL);
  assign spare_irq_level = route_high_reg ? spare_irq_req_i : ~spare_irq_req_i;

  // Routed interrupt takes priority over the general purpose use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      spare_pin_seven_o <= 1'b0;
      spare_pin_seven_oe_o <= 1'b0;
    end
    else if (spare_is_irq)
    begin
      spare_pin_seven_o <= spare_irq_level;
      spare_pin_seven_oe_o <= 1'b1;
    end
    else
    begin
      spare_pin_seven_o <= spare_data_reg;
      spare_pin_seven_oe_o <= spare_pin_seven_enable_reg;
    end
  end

endmodule

/* test/pdc_pin_model.sv */
`timescale 1ns/1ps

module pdc_pin_model
(
  // Pad drive from the block
  input wire logic [7:0] front_pins_o,
  input wire logic [7:0] front_pins_oe_o,
  input wire logic lock_enable_pin_o,
  input wire logic lock_enable_pin_oe_o,
  input wire logic [4:0] general_pin_o,
  input wire logic [4:0] general_pin_oe_o,
  input wire logic spare_pin_seven_o,
  input wire logic spare_pin_seven_oe_o,
  // Far-side drivers, seen only where the block floats
  input wire logic [7:0] ext_front_i,
  input wire logic ext_lock_i,
  input wire logic [4:0] ext_gen_i,
  input wire logic ext_spare_i,
  // Resolved pad levels
  output logic [7:0] front_lvl_o,
  output logic lock_lvl_o,
  output logic [4:0] gen_lvl_o,
  output logic spare_lvl_o
);
  assign front_lvl_o = (front_pins_oe_o & front_pins_o) | (~front_pins_oe_o & ext_front_i);
  assign lock_lvl_o = lock_enable_pin_oe_o ? lock_enable_pin_o : ext_lock_i;
  assign gen_lvl_o = (general_pin_oe_o & general_pin_o) | (~general_pin_oe_o & ext_gen_i);
  assign spare_lvl_o = spare_pin_seven_oe_o ? spare_pin_seven_o : ext_spare_i;
endmodule

/* test/pdc_top_monitor.sv */
`timescale 1ns/1ps

module pdc_top_monitor
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins
  input wire logic bus_mode_strap_i,
  input wire logic [7:0] front_fn_i,
  input wire logic [7:0] front_pins_o,
  input wire logic [7:0] front_pins_oe_o,
  input wire logic lock_enable_pin_o,
  input wire logic lock_enable_pin_oe_o,
  input wire logic [4:0] general_pin_o,
  input wire logic [4:0] general_pin_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_hit;
  assign wr_hit = wb_ack_o && wb_we_i && wb_sel_i[0];

  a_front_oe_write: assert property (wr_hit && wb_adr_i == 8'h34 |=> front_pins_oe_o == $past(wb_dat_i[7:0]))
    else $error("front enables wrong after write");
  a_gen_dir_write: assert property (wr_hit && wb_adr_i == 8'h38 |=> general_pin_oe_o == $past(wb_dat_i[4:0]))
    else $error("general enables wrong after write");
  a_gen_out_data: assert property (wr_hit && wb_adr_i == 8'h44 |=> general_pin_o == $past(wb_dat_i[4:0]))
    else $error("general outputs wrong after write");
  a_lock_out_data: assert property (wr_hit && wb_adr_i == 8'h40 |=> lock_enable_pin_o == $past(wb_dat_i[0]))
    else $error("lock output wrong after write");
  a_lock_hiz: assert property (wr_hit && wb_adr_i == 8'h38 && !wb_dat_i[6] |=> !lock_enable_pin_oe_o)
    else $error("lock pin driven with direction zero");
  a_lock_oe_strap: assert property ($rose(lock_enable_pin_oe_o) |-> $past(bus_mode_strap_i, 3))
    else $error("lock pin driven without strap");
  a_front_follow: assert property (!$past(rst_i) |-> front_pins_o == $past(front_fn_i))
    else $error("front outputs do not follow functions");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");

  cover property (wr_hit && wb_adr_i == 8'h40);
  cover property ($rose(lock_enable_pin_oe_o));
  cover property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h44);
endmodule

bind pdc_top pdc_top_monitor pdc_top_monitor_inst
(
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .bus_mode_strap_i(bus_mode_strap_i), .front_fn_i(front_fn_i), .front_pins_o(front_pins_o),
  .front_pins_oe_o(front_pins_oe_o), .lock_enable_pin_o(lock_enable_pin_o),
  .lock_enable_pin_oe_o(lock_enable_pin_oe_o), .general_pin_o(general_pin_o), .general_pin_oe_o(general_pin_oe_o)
);

/* test/tb_pdc_top.sv */
`timescale 1ns/1ps

module tb_pdc_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic strap = 1'b1;
  logic [7:0] front_fn = 8'ha5;
  logic [7:0] fr_o, fr_oe, fr_lvl;
  logic lk_o, lk_oe, lk_lvl, sp_o, sp_oe, sp_lvl;
  logic [4:0] gp_o, gp_oe, gp_lvl;
  logic [4:0] ext_gen = 5'h00;
  logic irq_req = 1'b0;
  logic [31:0] q;
  int bad_count = 0;
  int checks = 0;

  always #50 clk_i = ~clk_i;

  pdc_top pdc_top_inst
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .bus_mode_strap_i(strap), .front_fn_i(front_fn), .front_pins_i(fr_lvl), .front_pins_o(fr_o),
    .front_pins_oe_o(fr_oe), .lock_enable_pin_i(lk_lvl), .lock_enable_pin_o(lk_o), .lock_enable_pin_oe_o(lk_oe),
    .general_pin_i(gp_lvl), .general_pin_o(gp_o), .general_pin_oe_o(gp_oe), .spare_pin_seven_i(sp_lvl),
    .spare_irq_req_i(irq_req), .spare_pin_seven_o(sp_o), .spare_pin_seven_oe_o(sp_oe)
  );

  pdc_pin_model pdc_pin_model_inst
  (
    .front_pins_o(fr_o), .front_pins_oe_o(fr_oe), .lock_enable_pin_o(lk_o), .lock_enable_pin_oe_o(lk_oe),
    .general_pin_o(gp_o), .general_pin_oe_o(gp_oe), .spare_pin_seven_o(sp_o), .spare_pin_seven_oe_o(sp_oe),
    .ext_front_i(8'h3c), .ext_lock_i(1'b1), .ext_gen_i(ext_gen), .ext_spare_i(1'b0),
    .front_lvl_o(fr_lvl), .lock_lvl_o(lk_lvl), .gen_lvl_o(gp_lvl), .spare_lvl_o(sp_lvl)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    // No cycle count assumed; only the watchdog ends a hung wait
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic stop_test;
    $display("Mismatches %0d in %0d checks", bad_count, checks);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk_i);
    $display("Error at %0t: watchdog timeout", $time);
    bad_count++;
    stop_test;
  end

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    bus(1'b0, 8'h34, 8'h00, 4'hf);
    chk(q, 32'hff);
    bus(1'b0, 8'h38, 8'h00, 4'hf);
    chk(q, 32'h0);
    chk({19'h0, gp_oe, fr_oe}, 32'hff);
    chk({24'h0, fr_o}, 32'ha5);
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, 8'h34, ~(8'h01 << i), 4'hf);
      @(negedge clk_i);
      chk({24'h0, fr_oe}, {24'h0, ~(8'h01 << i)});
    end
    repeat (4) @(posedge clk_i);
    bus(1'b0, 8'h48, 8'h00, 4'hf);
    chk(q, 32'h25);
    // Driven front pins must track a changing function source
    front_fn <= 8'h5a;
    repeat (2) @(negedge clk_i);
    chk({24'h0, fr_o}, 32'h5a);
    repeat (4) @(posedge clk_i);
    bus(1'b0, 8'h48, 8'h00, 4'hf);
    chk(q, 32'h5a);
    // Ignored writes: byte lane off, then unmapped
    bus(1'b1, 8'h34, 8'h00, 4'he);
    bus(1'b1, 8'h7c, 8'h00, 4'hf);
    bus(1'b0, 8'h34, 8'h00, 4'hf);
    chk(q, 32'h7f);
    bus(1'b0, 8'h7c, 8'h00, 4'hf);
    chk(q, 32'h0);
    bus(1'b1, 8'h38, 8'h55, 4'hf);
    bus(1'b1, 8'h44, 8'h1f, 4'hf);
    bus(1'b0, 8'h38, 8'h00, 4'hf);
    chk(q, 32'h55);
    chk({22'h0, gp_oe, gp_o}, 32'h2bf);
    repeat (4) @(posedge clk_i);
    bus(1'b0, 8'h44, 8'h00, 4'hf);
    chk({27'h0, q[4:0]}, 32'h15);
    ext_gen <= 5'h0a;
    repeat (4) @(posedge clk_i);
    bus(1'b0, 8'h44, 8'h00, 4'hf);
    chk({27'h0, q[4:0]}, 32'h1f);
    bus(1'b1, 8'h40, 8'h01, 4'hf);
    @(negedge clk_i);
    chk({30'h0, lk_oe, lk_o}, 32'h3);
    bus(1'b1, 8'h40, 8'h00, 4'hf);
    repeat (4) @(posedge clk_i);
    bus(1'b0, 8'h40, 8'h00, 4'hf);
    chk({31'h0, q[0]}, 32'h0);
    strap <= 1'b0;
    repeat (6) @(posedge clk_i);
    bus(1'b0, 8'h40, 8'h00, 4'hf);
    chk({30'h0, lk_oe, q[0]}, 32'h1);
    bus(1'b1, 8'h38, 8'h00, 4'hf);
    strap <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk({31'h0, lk_oe}, 32'h0);
    bus(1'b1, 8'h38, 8'h80, 4'hf);
    bus(1'b1, 8'h44, 8'h80, 4'hf);
    @(negedge clk_i);
    chk({30'h0, sp_oe, sp_o}, 32'h3);
    // Plug-and-play mode with the shared level routes the request over the data bit
    @(posedge clk_i);
    strap <= 1'b0;
    bus(1'b1, 8'h4c, 8'h1b, 4'hf);
    @(negedge clk_i);
    chk({30'h0, sp_oe, sp_o}, 32'h2);
    @(posedge clk_i);
    irq_req <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk({30'h0, sp_oe, sp_o}, 32'h3);
    bus(1'b1, 8'h4c, 8'h0b, 4'hf);
    @(negedge clk_i);
    chk({30'h0, sp_oe, sp_o}, 32'h2);
    bus(1'b0, 8'h4c, 8'h00, 4'hf);
    chk(q, 32'h0b);
    // Second reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    bus(1'b0, 8'h38, 8'h00, 4'hf);
    chk(q, 32'h0);
    stop_test;
  end
endmodule
